//--- verilog/chpl_pkg.sv
// Package of constants for the card host bus pin logic
package chpl_pkg;
   // ************************************************************
   // Interface modes
   // ************************************************************
   typedef enum logic [1:0] {
      CHPL_MODE_MEM,
      CHPL_MODE_IO,
      CHPL_MODE_IDE
   } chpl_mode_e;
   // ************************************************************
   // Widths and reset values
   // ************************************************************
   localparam int CHPL_DW = 16;
   localparam int CHPL_BW = 8;
   localparam logic [15:0] CHPL_DATA_RST = 16'h0000;
   localparam logic [7:0] CHPL_ADDR_RST = 8'h00;
   localparam int CHPL_SYNC_STAGES = 2;
endpackage

//--- verilog/chpl_sync.sv
// Two-flop synchroniser for pin inputs, one per bit
`timescale 1ns/1ps
`default_nettype none
module chpl_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= RST;
         q <= RST;
      end else if (ce) begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule
`default_nettype wire

//--- verilog/chpl_top.sv
// Host port pin logic: mode select, data bus, acknowledge, Ultra DMA
`timescale 1ns/1ps
`default_nettype none
// Operation
// - True IDE: cable select low gives master, open (pulled high) gives slave.
// - Cable select ignored in memory and I/O card modes.
// - Memory mode: input acknowledge idle, I/O read strobe ignored.
// - Sixteen data lines carry data both ways in memory and I/O modes; here they only drive read data out in those modes.
// - Bit 0 is even byte LSB, bit 8 odd byte LSB.
// - True IDE task file uses low byte only; data transfers use 16 bits.
// - I/O mode: acknowledge low only when selected and answering I/O read.
// - True IDE: device drives DMA request to host.
// - I/O mode: read data driven while I/O read strobe or output enable low; True IDE: on I/O read strobe low or Ultra DMA data-in.
// - Ready deasserted pauses data-in; device holds until reasserted.
// - Ultra DMA write: capture a word on each strobe edge.
// - No strobe edges means no capture; device waits.
// - Stop asserted during Ultra DMA ends the current burst.
module chpl_top
   import chpl_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire logic CE,
   input wire logic ATA_SEL_N,
   input wire logic IO_MODE,
   input wire logic CABLE_SEL_N,
   input wire logic CARD_EN_N,
   input wire logic ADDR_HIT,
   input wire logic TASKFILE_SEL,
   input wire logic IO_RD_N,
   input wire logic OUT_EN_N,
   input wire logic [15:0] DATA_IN,
   output logic [15:0] DATA_OUT,
   output logic DATA_OE,
   output logic IN_ACK_N,
   output logic IS_MASTER,
   output logic [1:0] MODE,
   input wire logic DMA_WANT,
   output logic DMA_REQ,
   input wire logic DMA_ACK_N,
   input wire logic UDMA_READ,
   input wire logic UDMA_WRITE,
   input wire logic HOST_RDY_N,
   input wire logic HOST_STROBE,
   input wire logic STOP,
   input wire logic [15:0] RD_DATA,
   input wire logic RD_VALID,
   output logic RD_TAKEN,
   output logic [15:0] WR_DATA,
   output logic WR_VALID,
   output logic BURST_END
);
   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   localparam int NP = 11;
   logic [NP-1:0] pin_raw;
   logic [NP-1:0] pin_s;
   logic [15:0] din_s;
   assign pin_raw = {ATA_SEL_N, CABLE_SEL_N, CARD_EN_N, IO_RD_N, OUT_EN_N,
                     DMA_ACK_N, HOST_RDY_N, HOST_STROBE, STOP, ADDR_HIT, IO_MODE};
   chpl_sync #(.W(NP), .RST(11'h7F0)) u_sync_pins (
      .clk(CLK_SYS),
      .rst_n(RESETN),
      .ce(CE),
      .d(pin_raw),
      .q(pin_s)
   );
   // Data lines settle with the strobe; same two-flop delay keeps them aligned
   chpl_sync #(.W(CHPL_DW), .RST(CHPL_DATA_RST)) u_sync_data (
      .clk(CLK_SYS),
      .rst_n(RESETN),
      .ce(CE),
      .d(DATA_IN),
      .q(din_s)
   );
   logic ata_sel_n_s, csel_n_s, card_en_n_s, iord_n_s, oe_n_s;
   logic dmack_n_s, hrdy_n_s, hstb_s, stop_s, hit_s, io_mode_s;
   assign {ata_sel_n_s, csel_n_s, card_en_n_s, iord_n_s, oe_n_s,
           dmack_n_s, hrdy_n_s, hstb_s, stop_s, hit_s, io_mode_s} = pin_s;
   // ************************************************************
   // Mode and master/slave
   // ************************************************************
   chpl_mode_e mode_next;
   always_comb begin
      if (!ata_sel_n_s) begin
         mode_next = CHPL_MODE_IDE;
      end else if (io_mode_s) begin
         mode_next = CHPL_MODE_IO;
      end else begin
         mode_next = CHPL_MODE_MEM;
      end
   end
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         MODE <= 2'(CHPL_MODE_MEM);
      end else if (CE) begin
         MODE <= 2'(mode_next);
      end
   end
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         IS_MASTER <= 1'b0;
      end else if (CE) begin
         if (mode_next == CHPL_MODE_IDE) begin
            IS_MASTER <= !csel_n_s;
         end else begin
            IS_MASTER <= 1'b0;
         end
      end
   end
   // ************************************************************
   // Read path and acknowledge
   // ************************************************************
   logic io_rd_act;
   logic mem_rd_act;
   logic rd_act;
   logic udma_in_act;
   assign io_rd_act = (mode_next != CHPL_MODE_MEM) && !card_en_n_s && !iord_n_s && hit_s;
   assign mem_rd_act = (mode_next != CHPL_MODE_IDE) && !card_en_n_s && !oe_n_s;
   logic udma_run_reg;
   assign udma_in_act = udma_run_reg && UDMA_READ && !hrdy_n_s;
   assign rd_act = io_rd_act || mem_rd_act || udma_in_act;
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         IN_ACK_N <= 1'b1;
      end else if (CE) begin
         IN_ACK_N <= !((mode_next == CHPL_MODE_IO) && io_rd_act);
      end
   end
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         DATA_OE <= 1'b0;
         DATA_OUT <= CHPL_DATA_RST;
      end else if (CE) begin
         DATA_OE <= rd_act;
         if (!rd_act) begin
            DATA_OUT <= CHPL_DATA_RST;
         end else if (mode_next == CHPL_MODE_IDE && TASKFILE_SEL && !udma_in_act) begin
            DATA_OUT <= {CHPL_ADDR_RST, RD_DATA[7:0]};
         end else begin
            DATA_OUT <= RD_DATA;
         end
      end
   end
   // Data-in words advance one per cycle while ready is held
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         RD_TAKEN <= 1'b0;
      end else if (CE) begin
         RD_TAKEN <= udma_in_act && RD_VALID;
      end
   end
   // ************************************************************
   // DMA request and Ultra DMA burst control
   // ************************************************************
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         DMA_REQ <= 1'b0;
      end else if (CE) begin
         DMA_REQ <= (mode_next == CHPL_MODE_IDE) && DMA_WANT && !stop_s;
      end
   end
   logic burst_go;
   assign burst_go = (mode_next == CHPL_MODE_IDE) && !dmack_n_s && (UDMA_READ || UDMA_WRITE);
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         udma_run_reg <= 1'b0;
         BURST_END <= 1'b0;
      end else if (CE) begin
         BURST_END <= udma_run_reg && (stop_s || !burst_go);
         udma_run_reg <= burst_go && !stop_s;
      end
   end
   // ************************************************************
   // Ultra DMA write capture
   // ************************************************************
   logic hstb_d_reg;
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         hstb_d_reg <= 1'b0;
      end else if (CE) begin
         hstb_d_reg <= hstb_s;
      end
   end
   logic stb_edge;
   assign stb_edge = (hstb_s != hstb_d_reg) && udma_run_reg && UDMA_WRITE && !stop_s;
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         WR_VALID <= 1'b0;
         WR_DATA <= CHPL_DATA_RST;
      end else if (CE) begin
         WR_VALID <= stb_edge;
         if (stb_edge) begin
            WR_DATA <= din_s;
         end
      end
   end
   // ************************************************************
   // Checks
   // ************************************************************
   a_ack_only_io: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      !IN_ACK_N |-> MODE == 2'(CHPL_MODE_IO))
      else $error("acknowledge outside I/O mode");
   a_oe_needs_read: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && !$past(rd_act) && $past(CE) |-> !DATA_OE)
      else $error("data driven without read");
   a_no_slave_cfg: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      IS_MASTER |-> MODE == 2'(CHPL_MODE_IDE))
      else $error("master outside IDE mode");
   a_edge_capture: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && stb_edge |=> WR_VALID && WR_DATA == $past(din_s))
      else $error("strobe edge not captured");
   a_pause_hold: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && hstb_s == hstb_d_reg |=> !WR_VALID)
      else $error("capture without edge");
   a_stop_ends: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && stop_s && udma_run_reg |=> BURST_END && !udma_run_reg)
      else $error("stop did not end burst");
   a_ready_pause: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && hrdy_n_s |=> !RD_TAKEN)
      else $error("data sent while paused");
   a_dmarq_ide: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      DMA_REQ |-> MODE == 2'(CHPL_MODE_IDE))
      else $error("DMA request outside IDE");

   a_ack_needs_oe: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      !IN_ACK_N |-> DATA_OE)
      else $error("acknowledge without driven bus");

   a_mem_no_ack: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      MODE == 2'(CHPL_MODE_MEM) |-> IN_ACK_N)
      else $error("acknowledge in memory mode");

   a_ack_follows_rd: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && mode_next == CHPL_MODE_IO && io_rd_act |=> !IN_ACK_N)
      else $error("I/O read not acknowledged");

   a_oe_follows_rd: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && rd_act |=> DATA_OE)
      else $error("read strobe not answered");

   a_idle_bus_zero: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      !DATA_OE |-> DATA_OUT == CHPL_DATA_RST)
      else $error("idle bus not cleared");

   a_taskfile_byte: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && rd_act && mode_next == CHPL_MODE_IDE && TASKFILE_SEL && !udma_in_act |=> DATA_OUT[15:8] == 8'h00)
      else $error("task file read used upper byte");

   a_word_lanes: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && rd_act && !(mode_next == CHPL_MODE_IDE && TASKFILE_SEL && !udma_in_act) |=> DATA_OUT == $past(RD_DATA))
      else $error("word read lanes wrong");

   a_low_lane: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && rd_act |=> DATA_OUT[7:0] == $past(RD_DATA[7:0]))
      else $error("even byte lane wrong");

   a_mem_iord_off: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && mode_next == CHPL_MODE_MEM && oe_n_s && !udma_run_reg |=> !DATA_OE)
      else $error("I/O read strobe used in memory mode");

   a_master_cable: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && mode_next == CHPL_MODE_IDE |=> IS_MASTER == !$past(csel_n_s))
      else $error("master follows cable select wrongly");

   a_slave_off: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && mode_next != CHPL_MODE_IDE |=> !IS_MASTER)
      else $error("cable select used outside IDE");

   a_dmarq_stop: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && stop_s |=> !DMA_REQ)
      else $error("DMA request during stop");

   a_dmarq_want: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && mode_next == CHPL_MODE_IDE && DMA_WANT && !stop_s |=> DMA_REQ)
      else $error("DMA request missing");

   a_take_ready: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && udma_in_act && RD_VALID |=> RD_TAKEN)
      else $error("ready host not served");

   a_no_take_idle: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && !udma_run_reg |=> !RD_TAKEN)
      else $error("data-in outside burst");

   a_stop_no_cap: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && stop_s |=> !WR_VALID)
      else $error("capture during stop");

   a_end_pulse: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      BURST_END |-> !udma_run_reg)
      else $error("burst still running after end");

   a_no_write_idle: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && !udma_run_reg |=> !WR_VALID)
      else $error("capture outside burst");

   // Burst only lives while the host acknowledges
   a_run_needs_ack: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && dmack_n_s |=> !udma_run_reg)
      else $error("burst without acknowledge");
endmodule
`default_nettype wire

//--- verif/chpl_host.sv
// Host-side model driving the card port pins
`timescale 1ns/1ps
`default_nettype none
module chpl_host
   import chpl_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic IN_ACK_N,
   input wire logic [15:0] DATA_OUT,
   output logic ATA_SEL_N,
   output logic IO_MODE,
   output logic CABLE_SEL_N,
   output logic CARD_EN_N,
   output logic ADDR_HIT,
   output logic IO_RD_N,
   output logic OUT_EN_N,
   output logic [15:0] DATA_IN,
   output logic DMA_ACK_N,
   output logic HOST_RDY_N,
   output logic HOST_STROBE,
   output logic STOP
);
   logic [15:0] buf_reg;
   initial begin
      {ATA_SEL_N, IO_MODE, CABLE_SEL_N, CARD_EN_N, ADDR_HIT, IO_RD_N, OUT_EN_N} = 7'h5B;
      {DMA_ACK_N, HOST_RDY_N, HOST_STROBE, STOP} = 4'hC;
      DATA_IN = 16'h0000;
   end
   // Input buffers open only on acknowledge
   always @(posedge CLK_SYS) if (!IN_ACK_N) buf_reg <= DATA_OUT;
   task automatic setup(input logic [1:0] m, input logic cs);
      @(posedge CLK_SYS);
      ATA_SEL_N <= (m != CHPL_MODE_IDE);
      IO_MODE <= (m == CHPL_MODE_IO);
      CABLE_SEL_N <= cs;
   endtask
   task automatic rd(input logic io, input logic hit);
      @(posedge CLK_SYS);
      {CARD_EN_N, ADDR_HIT, IO_RD_N, OUT_EN_N} <= {1'b0, hit, !io, io};
   endtask
   task automatic rd_end();
      @(posedge CLK_SYS);
      {CARD_EN_N, ADDR_HIT, IO_RD_N, OUT_EN_N} <= 4'hB;
   endtask
   task automatic dma(input logic ack, input logic rdy, input logic stp);
      @(posedge CLK_SYS);
      DMA_ACK_N <= !ack;
      HOST_RDY_N <= !rdy;
      STOP <= stp;
   endtask
   // Strobe stands still between calls; bus inverted once its hold has run out
   task automatic edge_out(input logic [15:0] w);
      DATA_IN = w;
      #31.1 HOST_STROBE = !HOST_STROBE;
      #31.4 DATA_IN = ~w;
   endtask
endmodule
`default_nettype wire

//--- verif/test_chpl_top.sv
// Self-checking bench for the host port pin logic
`timescale 1ns/1ps
`default_nettype none
module test_chpl_top;
   import chpl_pkg::*;
   logic CLK_SYS, RESETN, CE, ATA_SEL_N, IO_MODE, CABLE_SEL_N, CARD_EN_N, ADDR_HIT, TASKFILE_SEL, IO_RD_N;
   logic OUT_EN_N, DATA_OE, IN_ACK_N, IS_MASTER, DMA_WANT, DMA_REQ, DMA_ACK_N, UDMA_READ, UDMA_WRITE;
   logic HOST_RDY_N, HOST_STROBE, STOP, RD_VALID, RD_TAKEN, WR_VALID, BURST_END, mst, oe_q = 1'b0;
   logic [15:0] DATA_IN, DATA_OUT, RD_DATA, WR_DATA, w;
   logic [1:0] MODE;
   logic [15:0] exp_wr[$], exp_rd[$];
   int n_mismatch = 0, n_checks = 0, n_taken = 0, n_end = 0, i;
   chpl_top uut (.*);
   chpl_host u_host (.*);
   initial begin
      CLK_SYS = 1'b0;
      forever #2 CLK_SYS = !CLK_SYS;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic rd_case(input logic [1:0] m, input logic io, hit, tf, oe, ack);
      logic [15:0] d;
      d = 16'($urandom);
      u_host.setup(m, 1'b1);
      TASKFILE_SEL <= tf;
      RD_DATA <= d;
      if (oe) exp_rd.push_back(tf ? {8'h00, d[7:0]} : d);
      repeat (4) @(posedge CLK_SYS);
      u_host.rd(io, hit);
      repeat (5) @(posedge CLK_SYS);
      chk(16'(DATA_OE), 16'(oe));
      chk(16'(IN_ACK_N), 16'(!ack));
      if (ack) chk(u_host.buf_reg, d);
      u_host.rd_end();
      repeat (5) @(posedge CLK_SYS);
      chk({15'h0000, DATA_OE} | DATA_OUT, 16'h0000);
   endtask
   // ************************************************************
   // Result watcher: unexpected results meet an unknown note
   // ************************************************************
   always @(posedge CLK_SYS) begin
      oe_q <= DATA_OE;
      if (RD_TAKEN) n_taken++;
      if (BURST_END) n_end++;
      if (WR_VALID) chk(WR_DATA, exp_wr.size() ? exp_wr.pop_front() : 16'hXXXX);
      if (DATA_OE && !oe_q && !UDMA_READ) chk(DATA_OUT, exp_rd.size() ? exp_rd.pop_front() : 16'hXXXX);
   end
   initial begin
      w = 16'($urandom(32'h79DE));
      {RESETN, CE, TASKFILE_SEL, DMA_WANT, UDMA_READ, UDMA_WRITE, RD_VALID} = 7'h20;
      RD_DATA = 16'h0000;
      repeat (10) @(posedge CLK_SYS);
      RESETN <= 1'b1;
      for (i = 0; i < 6; i++) begin
         u_host.setup(2'(i / 2), i[0]);
         repeat (5) @(posedge CLK_SYS);
         chk(16'(MODE), 16'(i / 2));
         if (i > 3) chk(16'(IS_MASTER), 16'(!i[0]));
         if (i < 4 && i[0]) chk(16'(IS_MASTER), 16'(mst));
         mst = IS_MASTER;
      end
      rd_case(CHPL_MODE_IO, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
      rd_case(CHPL_MODE_IO, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      rd_case(CHPL_MODE_MEM, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      rd_case(CHPL_MODE_MEM, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
      rd_case(CHPL_MODE_IDE, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
      rd_case(CHPL_MODE_IDE, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
      // Write burst with a pause after the fourth edge
      u_host.dma(1'b1, 1'b0, 1'b0);
      UDMA_WRITE <= 1'b1;
      repeat (5) @(posedge CLK_SYS);
      for (i = 0; i < 8; i++) begin
         w = 16'($urandom);
         exp_wr.push_back(w);
         u_host.edge_out(w);
         if (i == 3) #400;
      end
      for (i = 0; i < 100 && exp_wr.size() > 0; i++) @(posedge CLK_SYS);
      chk(16'(exp_wr.size()), 16'h0000);
      UDMA_WRITE <= 1'b0;
      UDMA_READ <= 1'b1;
      RD_VALID <= 1'b1;
      DMA_WANT <= 1'b1;
      repeat (6) @(posedge CLK_SYS);
      chk(16'(DMA_REQ), 16'h0001);
      i = n_taken;
      repeat (20) @(posedge CLK_SYS);
      chk(16'(n_taken - i), 16'h0000);
      u_host.dma(1'b1, 1'b1, 1'b0);
      repeat (20) @(posedge CLK_SYS);
      chk(16'(n_taken - i >= 10), 16'h0001);
      chk(16'(DATA_OE), 16'h0001);
      chk(DATA_OUT, RD_DATA);
      i = n_end;
      u_host.dma(1'b1, 1'b1, 1'b1);
      repeat (8) @(posedge CLK_SYS);
      chk(16'(DMA_REQ), 16'h0000);
      chk(16'(n_end - i), 16'h0001);
      u_host.dma(1'b0, 1'b0, 1'b0);
      finish_test();
   end
endmodule
`default_nettype wire
